// File: hw/i2cs_status.sv
`timescale 1ns/1ps
// Contract
// - master transmit: ack slot sets ack result
// - tx active from start through ack
// - collision flag set by hardware, software clears
// - general call sets flag, stop clears
// - ten-bit second byte match sets flag
// - tx write while busy rejected, flagged
// - receive while buffer full sets overflow
// - data/address bit tracks last byte kind
// - stop sets stop bit, start clears
// - start sets start bit, stop clears
// - address byte sets direction bit
// - rx full set on load, read clears
// - tx full set on write, cleared when sent
// - mask bit one ignores that address bit
// - mask upper bits zero, resets to zero
// - full byte moves to buffer, one pulse
// - config selects ten or seven bit address
module i2cs_status
    import i2cs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic master_mode,
    input wire logic master_tx_go,
    input wire logic bus_collision,
    input wire logic module_busy,
    output logic [7:0] tx_byte,
    output logic rx_byte_pulse,
    output logic irq
);
    import i2cs_pkg::*;

    // whole module state in one record
    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        i2cs_rx_t st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] first;
        logic in_frame;
        i2cs_flags_t fl;
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] own;
        logic ten_sel;
        logic gc_en;
        logic [7:0] tx_hold;
        logic [7:0] rx_hold;
        logic rx_pulse;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic acked;
        logic [31:0] rdata;
    } i2cs_state_t;

    i2cs_state_t s_q; // registered state
    i2cs_state_t s_d; // next state
    i2cs_avreq_t req; // bus request bundle
    logic scl_s; // synchronised clock pin
    logic sda_s; // synchronised data pin

    // pins come from another domain: two flops each before use
    i2cs_sync2 u_sync_scl (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(scl_in),
        .dout(scl_s)
    );
    i2cs_sync2 u_sync_sda (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(sda_in),
        .dout(sda_s)
    );

    assign req = '{address: avs_address, read: avs_read, write: avs_write,
                   writedata: avs_writedata};

    // status word as software sees it; unused bits read zero
    function automatic logic [31:0] status_word(input i2cs_flags_t f);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[B_ACK] = f.ack;
        w[B_TXACT] = f.txact;
        w[B_COL] = f.col;
        w[B_GC] = f.gc;
        w[B_TEN] = f.ten;
        w[B_WCOL] = f.wcol;
        w[B_OVF] = f.ovf;
        w[B_DA] = f.da;
        w[B_STOP] = f.stop;
        w[B_START] = f.start;
        w[B_RW] = f.rw;
        w[B_RXF] = f.rxf;
        w[B_TXF] = f.txf;
        return w;
    endfunction : status_word

    // masked compare: a one in the mask ignores that bit
    function automatic logic addr_eq(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b,
                                     input logic [ADDR_W-1:0] m);
        return ((a ^ b) & ~m) == '0;
    endfunction : addr_eq

    // next-state logic for pins, flags and registers
    always_comb begin
        logic scl_rise;
        logic start_ev;
        logic stop_ev;
        logic byte_done;
        logic ack_edge;
        logic [7:0] rx_byte;
        logic [IRQ_W-1:0] ev;
        logic hit;
        logic wr_now;
        logic rd_now;
        scl_rise = 1'b0;
        start_ev = 1'b0;
        stop_ev = 1'b0;
        byte_done = 1'b0;
        ack_edge = 1'b0;
        rx_byte = 8'h00;
        ev = '0;
        hit = 1'b0;
        wr_now = 1'b0;
        rd_now = 1'b0;
        s_d = s_q;
        s_d.scl_prev = scl_s;
        s_d.sda_prev = sda_s;
        s_d.rx_pulse = 1'b0;
        s_d.acked = 1'b0;

        // line conditions: data moves while the clock is high
        scl_rise = scl_s & ~s_q.scl_prev;
        start_ev = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
        stop_ev = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;

        // bit counter: eight data bits then the ack slot
        if (start_ev) begin
            s_d.in_frame = 1'b1;
            s_d.bitcnt = '0;
        end else if (stop_ev) begin
            s_d.in_frame = 1'b0;
            s_d.bitcnt = '0;
        end else if (scl_rise && s_q.in_frame) begin
            if (s_q.bitcnt == 4'(ACK_BIT)) begin
                ack_edge = 1'b1;
                s_d.bitcnt = '0;
            end else begin
                s_d.shreg = {s_q.shreg[6:0], sda_s};
                s_d.bitcnt = s_q.bitcnt + 4'h1;
                byte_done = (s_q.bitcnt == 4'(DATA_BIT_LAST));
            end
        end
        rx_byte = {s_q.shreg[6:0], sda_s};

        // master transmit tracking
        if (master_tx_go) begin
            s_d.fl.txact = 1'b1;
        end else if (ack_edge && s_q.fl.txact) begin
            s_d.fl.txact = 1'b0;
            s_d.fl.ack = sda_s;
            s_d.fl.txf = 1'b0;
        end

        // start and stop history
        if (start_ev) begin
            s_d.fl.start = 1'b1;
            s_d.fl.stop = 1'b0;
            s_d.st = (master_mode) ? RX_SKIP : RX_ADDR1;
        end else if (stop_ev) begin
            s_d.fl.stop = 1'b1;
            s_d.fl.start = 1'b0;
            s_d.fl.gc = 1'b0;
            s_d.fl.ten = 1'b0;
            s_d.st = RX_IDLE;
            ev[I_STOP] = 1'b1;
        end else if (byte_done) begin
            // slave receive sequence
            case (s_q.st)
                RX_ADDR1: begin
                    s_d.first = rx_byte;
                    if (s_q.gc_en && rx_byte == GC_ADDR) begin
                        s_d.fl.gc = 1'b1;
                        s_d.fl.da = 1'b0;
                        s_d.fl.rw = 1'b0;
                        s_d.st = RX_DATA;
                    end else if (s_q.ten_sel) begin
                        // ten-bit header carries the top two bits
                        hit = (rx_byte[7:3] == TEN_HDR) && addr_eq(
                            {rx_byte[2:1], 8'h00}, {s_q.own[9:8], 8'h00}, s_q.mask);
                        if (hit && rx_byte[0] && s_q.fl.ten) begin
                            // repeated start read after a full match
                            s_d.fl.da = 1'b0;
                            s_d.fl.rw = 1'b1;
                            s_d.st = RX_SKIP;
                        end else begin
                            s_d.st = hit ? RX_ADDR2 : RX_SKIP;
                        end
                    end else begin
                        hit = addr_eq({3'b000, rx_byte[7:1]}, {3'b000, s_q.own[6:0]},
                                      s_q.mask);
                        if (hit) begin
                            s_d.fl.da = 1'b0;
                            s_d.fl.rw = rx_byte[0];
                        end
                        s_d.st = (hit && !rx_byte[0]) ? RX_DATA : RX_SKIP;
                    end
                end
                RX_ADDR2: begin
                    hit = addr_eq({s_q.first[2:1], rx_byte}, s_q.own, s_q.mask);
                    if (hit) begin
                        s_d.fl.ten = 1'b1;
                        s_d.fl.da = 1'b0;
                        s_d.fl.rw = s_q.first[0];
                    end
                    s_d.st = hit ? RX_DATA : RX_SKIP;
                end
                RX_DATA: begin
                    s_d.fl.da = 1'b1;
                    if (s_q.fl.rxf) begin
                        // buffer still unread: keep old byte, flag it
                        s_d.fl.ovf = 1'b1;
                        ev[I_OVF] = 1'b1;
                    end else begin
                        s_d.rx_hold = rx_byte;
                        s_d.fl.rxf = 1'b1;
                        s_d.rx_pulse = 1'b1;
                        ev[I_RX] = 1'b1;
                    end
                end
                RX_IDLE, RX_SKIP: begin
                    s_d.st = s_q.st;
                end
                default: begin
                    s_d.st = RX_IDLE;
                end
            endcase
        end

        // collision is reported by the master sequencer
        if (bus_collision) begin
            s_d.fl.col = 1'b1;
            ev[I_COL] = 1'b1;
        end

        // avalon access: one wait cycle, taken on the second edge
        wr_now = req.write & s_q.acked;
        rd_now = req.read & s_q.acked;
        s_d.acked = (req.read | req.write) & ~s_q.acked;
        if (wr_now) begin
            case (req.address)
                OFS_STATUS: begin
                    // only clear-only bits react, and only to a zero
                    if (avs_byteenable[1] && !req.writedata[B_COL]) begin
                        s_d.fl.col = bus_collision;
                    end
                    if (avs_byteenable[0]) begin
                        if (!req.writedata[B_WCOL]) begin
                            s_d.fl.wcol = 1'b0;
                        end
                        if (!req.writedata[B_OVF]) begin
                            // an overflow in this same cycle wins over the clear
                            s_d.fl.ovf = ev[I_OVF];
                        end
                    end
                end
                OFS_MASK: begin
                    if (avs_byteenable[0]) begin
                        s_d.mask[7:0] = req.writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        s_d.mask[ADDR_W-1:8] = req.writedata[ADDR_W-1:8];
                    end
                end
                OFS_TX: begin
                    if (module_busy || s_q.fl.txact) begin
                        s_d.fl.wcol = 1'b1;
                        ev[I_WCOL] = 1'b1;
                    end else if (avs_byteenable[0]) begin
                        s_d.tx_hold = req.writedata[7:0];
                        s_d.fl.txf = 1'b1;
                    end
                end
                OFS_CFG: begin
                    s_d.own = req.writedata[C_ADDR_LO +: ADDR_W];
                    s_d.ten_sel = req.writedata[C_TEN_SEL];
                    s_d.gc_en = req.writedata[C_GC_EN];
                end
                OFS_IRQ_MASK: begin
                    s_d.irq_msk = req.writedata[IRQ_W-1:0];
                end
                default: begin
                    s_d.rdata = s_d.rdata; // unmapped writes are dropped
                end
            endcase
        end
        if (rd_now && req.address == OFS_RX) begin
            s_d.fl.rxf = s_d.rx_pulse;
        end

        // read data: read-clear of irq status loses no new event
        if (s_d.acked && req.read) begin
            case (req.address)
                OFS_STATUS: s_d.rdata = status_word(s_q.fl);
                OFS_MASK: s_d.rdata = {22'h000000, s_q.mask};
                OFS_TX: s_d.rdata = {24'h000000, s_q.tx_hold};
                OFS_RX: s_d.rdata = {24'h000000, s_q.rx_hold};
                OFS_CFG: s_d.rdata = {20'h00000, s_q.gc_en, s_q.ten_sel, s_q.own};
                OFS_IRQ_MASK: s_d.rdata = {27'h0000000, s_q.irq_msk};
                OFS_IRQ_STAT: s_d.rdata = {27'h0000000, s_q.irq_st};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (rd_now && req.address == OFS_IRQ_STAT) begin
            // clear only what the read reported; later events stay pending
            s_d.irq_st = (s_q.irq_st & ~s_q.rdata[IRQ_W-1:0]) | ev;
        end else begin
            s_d.irq_st = s_q.irq_st | ev;
        end
    end

    // single state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.scl_prev <= 1'b1;
            s_q.sda_prev <= 1'b1;
            s_q.st <= RX_IDLE;
            s_q.mask <= MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.acked;
    assign avs_readdata = s_q.rdata;
    assign tx_byte = s_q.tx_hold;
    assign rx_byte_pulse = s_q.rx_pulse;
    assign irq = |(s_q.irq_st & s_q.irq_msk);
endmodule : i2cs_status

// File: hw/i2cs_pkg.sv
package i2cs_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_MASK = 5'h04;
    localparam logic [4:0] OFS_TX = 5'h08;
    localparam logic [4:0] OFS_RX = 5'h0C;
    localparam logic [4:0] OFS_CFG = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h14;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
    // bus_status bit positions
    localparam int B_ACK = 15;
    localparam int B_TXACT = 14;
    localparam int B_COL = 10;
    localparam int B_GC = 9;
    localparam int B_TEN = 8;
    localparam int B_WCOL = 7;
    localparam int B_OVF = 6;
    localparam int B_DA = 5;
    localparam int B_STOP = 4;
    localparam int B_START = 3;
    localparam int B_RW = 2;
    localparam int B_RXF = 1;
    localparam int B_TXF = 0;
    // config register layout
    localparam int C_ADDR_LO = 0;
    localparam int C_TEN_SEL = 10;
    localparam int C_GC_EN = 11;
    // interrupt event bits
    localparam int I_RX = 0;
    localparam int I_COL = 1;
    localparam int I_OVF = 2;
    localparam int I_WCOL = 3;
    localparam int I_STOP = 4;
    localparam int IRQ_W = 5;
    // widths, reset values and bus constants
    localparam int ADDR_W = 10;
    localparam int DATA_BIT_LAST = 7;
    localparam int ACK_BIT = 8;
    localparam logic [ADDR_W-1:0] MASK_RST = 10'h000;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [4:0] TEN_HDR = 5'h1E;
    // slave receive states, one-hot
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_ADDR1 = 5'b00010,
        RX_ADDR2 = 5'b00100,
        RX_DATA = 5'b01000,
        RX_SKIP = 5'b10000
    } i2cs_rx_t;
    // status flags as one carrier
    typedef struct packed {
        logic ack;
        logic txact;
        logic col;
        logic gc;
        logic ten;
        logic wcol;
        logic ovf;
        logic da;
        logic stop;
        logic start;
        logic rw;
        logic rxf;
        logic txf;
    } i2cs_flags_t;
    // avalon request group
    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } i2cs_avreq_t;
endpackage : i2cs_pkg

// File: hw/i2cs_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser; first stage is read only by the second
module i2cs_sync2 (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic din,
    output logic dout
);
    logic meta_q; // first stage, seen by nothing else
    // pins idle high, so reset to one to avoid a false start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : i2cs_sync2

// File: sim/i2cs_status_properties.sv
`timescale 1ns/1ps
// watches the avalon answer and the event outputs of the status block
module i2cs_status_properties
    import i2cs_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic module_busy,
    input wire logic [7:0] tx_byte,
    input wire logic rx_byte_pulse,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // request raised and still waiting
    sequence req_open;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // read answered at this edge
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    // holding register written while the shifter is busy
    sequence busy_tx_write;
        avs_write && !avs_waitrequest && module_busy && (avs_address == OFS_TX);
    endsequence
    wait_one_a: assert property (req_open |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    // read data may only move at the edge that ends a read's wait cycle
    data_stands_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    mask_upper_a: assert property (
        rd_done ##0 (avs_address == OFS_MASK) |-> avs_readdata[31:10] == 22'h000000)
        else $error("mask upper bits not zero");
    status_gap_a: assert property (
        rd_done ##0 (avs_address == OFS_STATUS) |->
        avs_readdata[31:16] == 16'h0000 && avs_readdata[13:11] == 3'h0)
        else $error("status unused bits not zero");
    unmapped_zero_a: assert property (
        rd_done ##0 (avs_address > OFS_IRQ_STAT) |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    busy_hold_a: assert property (busy_tx_write |=> $stable(tx_byte))
        else $error("busy write changed holding data");
    pulse_single_a: assert property (rx_byte_pulse |=> !rx_byte_pulse)
        else $error("receive pulse longer than one cycle");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !irq && !rx_byte_pulse && tx_byte == 8'h00)
        else $error("outputs not quiet after reset");
endmodule : i2cs_status_properties

bind i2cs_status i2cs_status_properties i_props (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .module_busy(module_busy), .tx_byte(tx_byte), .rx_byte_pulse(rx_byte_pulse), .irq(irq));

// File: sim/i2cs_bus_model.sv
`timescale 1ns/1ps
// far-side bus master; scl stands high between frames, sda pulled up when let go
module i2cs_bus_model (
    input wire logic clk,
    output logic scl,
    output logic sda
);
    // both lines idle high through reset
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // wait whole clock cycles; 10 cycles is half of the 80 ns link period
    task automatic w(int n);
        repeat (n) @(posedge clk);
    endtask : w
    // start or repeated start: sda falls while scl high
    task automatic start();
        sda <= 1'b1;
        w(5);
        scl <= 1'b1;
        w(5);
        sda <= 1'b0;
        w(10);
        scl <= 1'b0;
        w(5);
    endtask : start
    // one bit, data settled before scl rises
    task automatic put_bit(logic b);
        sda <= b;
        w(5);
        scl <= 1'b1;
        w(10);
        scl <= 1'b0;
        w(5);
    endtask : put_bit
    // msb first, then the acknowledge slot, then let sda go
    task automatic send_byte(logic [7:0] b, logic a);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        put_bit(a);
        sda <= 1'b1;
    endtask : send_byte
    // stop: sda rises while scl high, clock then stands high
    task automatic stop();
        sda <= 1'b0;
        w(5);
        scl <= 1'b1;
        w(5);
        sda <= 1'b1;
        w(10);
    endtask : stop
endmodule : i2cs_bus_model

// File: sim/tb.sv
`timescale 1ns/1ps
// status block bench: avalon host on one side, bus master model on the other
module tb;
    import i2cs_pkg::*;
    // single status bits as word masks
    localparam logic [31:0] S_ACK = 32'h1 << B_ACK;
    localparam logic [31:0] S_TXACT = 32'h1 << B_TXACT;
    localparam logic [31:0] S_COL = 32'h1 << B_COL;
    localparam logic [31:0] S_GC = 32'h1 << B_GC;
    localparam logic [31:0] S_TEN = 32'h1 << B_TEN;
    localparam logic [31:0] S_WCOL = 32'h1 << B_WCOL;
    localparam logic [31:0] S_OVF = 32'h1 << B_OVF;
    localparam logic [31:0] S_DA = 32'h1 << B_DA;
    localparam logic [31:0] S_STOP = 32'h1 << B_STOP;
    localparam logic [31:0] S_START = 32'h1 << B_START;
    localparam logic [31:0] S_RW = 32'h1 << B_RW;
    localparam logic [31:0] S_RXF = 32'h1 << B_RXF;
    localparam logic [31:0] S_TXF = 32'h1 << B_TXF;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic scl;
    logic sda;
    logic master_mode = 1'b0;
    logic master_tx_go = 1'b0;
    logic bus_collision = 1'b0;
    logic module_busy = 1'b0;
    logic [7:0] tx_byte;
    logic rx_byte_pulse;
    logic irq;
    int failures = 0;
    int cmp_count = 0;
    // notes of expected read results, oldest first
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    string nm_q[$];
    logic [31:0] r;
    // 4 ns clock
    initial begin
        forever #2 clk = ~clk;
    end
    i2cs_status i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_in(scl), .sda_in(sda),
        .master_mode(master_mode), .master_tx_go(master_tx_go),
        .bus_collision(bus_collision), .module_busy(module_busy), .tx_byte(tx_byte),
        .rx_byte_pulse(rx_byte_pulse), .irq(irq));
    i2cs_bus_model i_bus (.clk(clk), .scl(scl), .sda(sda));
    // one compare, counted; four-state equality so unknowns fail
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // avalon cycle: request held until waitrequest is seen low at an edge
    // no cycle count assumed: only the watchdog ends a wait that never answers
    task automatic bus(logic [4:0] a, logic is_wr, logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !is_wr;
        avs_write <= is_wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(logic [4:0] a, logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    // read with the expectation noted first; the monitor compares it
    task automatic rd(logic [4:0] a, logic [31:0] e, logic [31:0] m, string nm);
        exp_q.push_back(e);
        msk_q.push_back(m);
        nm_q.push_back(nm);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    // monitor: each answered read takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(nm_q.pop_front(), avs_readdata & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    // a design output compared at once, as the caller samples it; no edge is waited here
    task automatic pin(string nm, logic [31:0] seen_now, logic [31:0] e);
        check(nm, seen_now, e);
    endtask : pin
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    // watchdog, well above the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(42));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFS_MASK, 32'h0, 32'hFFFFFFFF, "mask_reset");
        rd(OFS_STATUS, 32'h0, 32'hFFFF, "status_reset");
        wr(OFS_MASK, 32'hFFFFFFFF);
        rd(OFS_MASK, 32'h3FF, 32'hFFFFFFFF, "mask_top");
        repeat (4) begin
            r = $urandom();
            wr(OFS_MASK, r);
            rd(OFS_MASK, r & 32'h3FF, 32'hFFFFFFFF, "mask_rand");
        end
        // own address 5A in 7-bit mode, bit 0 masked
        wr(OFS_MASK, 32'h1);
        wr(OFS_CFG, 32'h5A);
        wr(OFS_IRQ_MASK, 32'h1F);
        i_bus.start();
        i_bus.send_byte(8'h94, 1'b0);
        i_bus.send_byte(8'h33, 1'b0);
        rd(OFS_STATUS, 32'h0, S_RXF, "no_match");
        i_bus.start();
        i_bus.send_byte(8'hB6, 1'b0);
        rd(OFS_STATUS, S_START, S_DA | S_RW | S_START | S_STOP, "addr_match");
        r = $urandom();
        i_bus.send_byte(r[7:0], 1'b0);
        pin("irq_rx", {31'h0, irq}, 32'h1);
        rd(OFS_STATUS, S_DA | S_RXF, S_DA | S_RXF | S_OVF, "data_in");
        i_bus.send_byte(8'h5C, 1'b0);
        rd(OFS_STATUS, S_OVF | S_RXF, S_OVF | S_RXF, "overflow");
        rd(OFS_RX, {24'h0, r[7:0]}, 32'hFFFFFFFF, "rx_kept");
        rd(OFS_IRQ_STAT, 32'h5, 32'h5, "irq_events");
        @(posedge clk);
        pin("irq_clear", {31'h0, irq}, 32'h0);
        wr(OFS_STATUS, 32'h0);
        rd(OFS_STATUS, 32'h0, S_OVF | S_RXF, "ovf_clear");
        i_bus.stop();
        rd(OFS_STATUS, S_STOP, S_STOP | S_START, "stop_seen");
        // general call, then a 10-bit address 2B5
        wr(OFS_CFG, 32'h85A);
        i_bus.start();
        i_bus.send_byte(GC_ADDR, 1'b0);
        rd(OFS_STATUS, S_GC | S_START, S_GC | S_START | S_STOP, "gen_call");
        i_bus.stop();
        rd(OFS_STATUS, 32'h0, S_GC, "gc_cleared");
        wr(OFS_MASK, 32'h0);
        wr(OFS_CFG, 32'h6B5);
        i_bus.start();
        i_bus.send_byte(8'hF4, 1'b0);
        i_bus.send_byte(8'hB5, 1'b0);
        rd(OFS_STATUS, S_TEN, S_TEN | S_DA | S_RW, "ten_match");
        // repeated start with a read header after the full match
        i_bus.start();
        i_bus.send_byte(8'hF5, 1'b0);
        rd(OFS_STATUS, S_TEN | S_RW, S_TEN | S_DA | S_RW, "ten_read");
        i_bus.stop();
        rd(OFS_STATUS, 32'h0, S_TEN, "ten_cleared");
        // master side: busy write refused, then two bytes, nack then ack
        master_mode <= 1'b1;
        module_busy <= 1'b1;
        wr(OFS_TX, 32'hA5);
        rd(OFS_STATUS, S_WCOL, S_WCOL | S_TXF, "wcol_set");
        @(posedge clk);
        pin("tx_refused", {24'h0, tx_byte}, 32'h0);
        module_busy <= 1'b0;
        wr(OFS_STATUS, 32'h0);
        // bits are only counted inside a frame, so open one first
        i_bus.start();
        for (int k = 1; k >= 0; k--) begin
            r = $urandom();
            wr(OFS_TX, {24'h0, r[7:0]});
            @(posedge clk);
            pin("tx_byte", {24'h0, tx_byte}, {24'h0, r[7:0]});
            rd(OFS_STATUS, S_TXF, S_TXF | S_WCOL, "tx_full");
            master_tx_go <= 1'b1;
            @(posedge clk);
            master_tx_go <= 1'b0;
            rd(OFS_STATUS, S_TXACT, S_TXACT, "tx_active");
            i_bus.send_byte(r[7:0], k[0]);
            rd(OFS_STATUS, k[0] ? S_ACK : 32'h0, S_ACK | S_TXACT | S_TXF, "ack_slot");
        end
        // collision while its interrupt is masked
        wr(OFS_IRQ_MASK, 32'h0);
        rd(OFS_IRQ_STAT, 32'h18, 32'h1F, "irq_flush");
        bus_collision <= 1'b1;
        @(posedge clk);
        bus_collision <= 1'b0;
        repeat (2) rd(OFS_STATUS, S_COL, S_COL, "collision");
        pin("irq_masked", {31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STAT, 32'h2, 32'h1F, "irq_col");
        wr(OFS_STATUS, 32'h0);
        rd(OFS_STATUS, 32'h0, S_COL, "col_clear");
        rd(5'h1C, 32'h0, 32'hFFFFFFFF, "unmapped");
        close_out();
    end
endmodule : tb
